// >>> smcg_ctrl.sv
// Sleep mode sequencer, clock gating and general-purpose port pins.
// =====================================================================
`timescale 1ns/1ps
`include "smcg_defines.svh"

module smcg_ctrl #(
  parameter int unsigned PORT_W   = `SMCG_PORT_W,
  parameter int unsigned NPORTS   = `SMCG_NUM_PORTS,
  parameter int unsigned OSC_CYC  = `SMCG_OSC_START_CYC,
  parameter int unsigned FAST_CYC = `SMCG_FAST_WAKE_CYC,
  parameter int unsigned RST_CYC  = `SMCG_RST_MIN_CYC
) (
  input  wire logic                     i_core_clk,
  input  wire logic                     i_rst,
  input  wire logic                     i_clk_en,
  input  wire logic                     i_reset_n,
  input  wire logic                     i_sleep_req,
  input  wire logic [`SMCG_MODE_W-1:0]  i_sleep_mode,
  input  wire logic                     i_wake_irq,
  input  wire logic [NPORTS*PORT_W-1:0] i_port_out,
  input  wire logic [NPORTS*PORT_W-1:0] i_port_dir,
  input  wire logic [NPORTS*PORT_W-1:0] i_port_pullup,
  input  wire logic [NPORTS*PORT_W-1:0] i_pin_in,
  output logic      [NPORTS*PORT_W-1:0] o_pin_out,
  output logic      [NPORTS*PORT_W-1:0] o_pin_oe,
  output logic      [NPORTS*PORT_W-1:0] o_pin_pullup,
  output logic      [NPORTS*PORT_W-1:0] o_port_in,
  output smcg_pkg::smcg_gate_s          o_gate,
  output logic                          o_sleeping,
  output logic                          o_cpu_run,
  output logic                          o_reset_active
);

  // ===================================================================
  // Elaboration checks.
  if (PORT_W != `SMCG_PORT_W) begin : g_bad_width
    $error("Port width must be eight bits.");
  end
  if (OSC_CYC < 1 || FAST_CYC < 1 || RST_CYC < 1) begin : g_bad_cnt
    $error("Timing counts must be at least one cycle.");
  end
  // The wake and filter counters are CNT_W bits wide. A longer count
  // would wrap, ending the oscillator wait or the pin filter early.
  if (OSC_CYC >= (1 << `SMCG_CNT_W) || RST_CYC >= (1 << `SMCG_CNT_W)) begin : g_big_cnt
    $error("Timing counts exceed the counter width.");
  end
  // The fast resync count shares the same counter.
  if (FAST_CYC >= (1 << `SMCG_CNT_W)) begin : g_big_fast
    $error("Fast wake count exceeds the counter width.");
  end

  // ===================================================================
  // State registers.
  smcg_pkg::smcg_all_s s_reg;  // Registered state.
  smcg_pkg::smcg_all_s s_next; // Next state.
  logic                rst_any; // Any reset source active.

  // Any reset source tri-states the pins combinationally, so the pins
  // float even when no clock edge arrives.
  assign rst_any = i_rst | s_reg.int_rst | ~i_reset_n;

  // Full-speed gate settings, everything on.
  localparam smcg_pkg::smcg_gate_s GATE_ALL = '{default: 1'b1};

  // Gate settings for a sleep mode; reserved codes keep all clocks.
  function automatic smcg_pkg::smcg_gate_s mode_gate(input logic [2:0] m);
    smcg_pkg::smcg_gate_s g;
    g = '0;
    case (m)
      `SMCG_MODE_IDLE: begin
        g = GATE_ALL;
        g.cpu = 1'b0;
        g.adc = 1'b0;
      end
      `SMCG_MODE_ADCNR: begin
        g.adc   = 1'b1;
        g.async = 1'b1;
        g.osc   = 1'b1;
      end
      `SMCG_MODE_PDOWN: begin
        g = '0;
      end
      `SMCG_MODE_PSAVE: begin
        g.async = 1'b1;
      end
      `SMCG_MODE_STBY: begin
        g.osc = 1'b1;
      end
      `SMCG_MODE_XSTBY: begin
        g.osc   = 1'b1;
        g.async = 1'b1;
      end
      default: begin
        g = GATE_ALL;
      end
    endcase
    return g;
  endfunction : mode_gate

  // True for the six valid codes.
  function automatic logic mode_valid(input logic [2:0] m);
    logic v;
    v = 1'b0;
    case (m)
      `SMCG_MODE_IDLE, `SMCG_MODE_ADCNR, `SMCG_MODE_PDOWN,
      `SMCG_MODE_PSAVE, `SMCG_MODE_STBY, `SMCG_MODE_XSTBY: v = 1'b1;
      default: v = 1'b0;
    endcase
    return v;
  endfunction : mode_valid

  // ===================================================================
  // Next-state logic.
  // The pin filter is evaluated first and the reset override last, so a
  // filtered reset always wins over any sleep or wake decision.
  always_comb begin
    s_next = s_reg;
    // Reset pin filter: a short low glitch does not reset the device.
    if (i_reset_n) begin
      s_next.rst_cnt = '0;
      s_next.int_rst = 1'b0;
    end else if (s_reg.rst_cnt >= 16'(RST_CYC - 1)) begin
      s_next.int_rst = 1'b1;
    end else begin
      s_next.rst_cnt = s_reg.rst_cnt + 16'h0001;
    end
    case (s_reg.state)
      smcg_pkg::SMCG_RESET: begin
        // Leave reset through the oscillator wait.
        s_next.gate  = GATE_ALL;
        s_next.gate.cpu = 1'b0;
        s_next.cnt   = 16'(OSC_CYC);
        s_next.state = smcg_pkg::SMCG_WAKE;
      end
      smcg_pkg::SMCG_ACTIVE: begin
        s_next.gate = GATE_ALL;
        // Reserved codes are ignored so they never gate a clock.
        if (i_sleep_req && mode_valid(i_sleep_mode)) begin
          s_next.mode  = i_sleep_mode;
          s_next.gate  = mode_gate(i_sleep_mode);
          s_next.state = smcg_pkg::SMCG_SLEEP;
        end
      end
      smcg_pkg::SMCG_SLEEP: begin
        if (i_wake_irq) begin
          // Clocks come back first; the CPU waits for a stable
          // oscillator. A kept oscillator needs only a short resync.
          s_next.gate     = GATE_ALL;
          s_next.gate.cpu = 1'b0;
          s_next.cnt      = s_reg.gate.osc ? 16'(FAST_CYC) : 16'(OSC_CYC);
          s_next.state    = smcg_pkg::SMCG_WAKE;
        end
      end
      smcg_pkg::SMCG_WAKE: begin
        if (s_reg.cnt <= 16'h0001) begin
          s_next.cnt   = '0;
          s_next.gate  = GATE_ALL;
          s_next.state = smcg_pkg::SMCG_ACTIVE;
        end else begin
          s_next.cnt = s_reg.cnt - 16'h0001;
        end
      end
      default: begin
        s_next.state = smcg_pkg::SMCG_RESET;
      end
    endcase
    // Only the filtered reset pin overrides the sequence here; i_rst acts in the state register.
    if (s_reg.int_rst) begin
      s_next.state = smcg_pkg::SMCG_RESET;
      s_next.gate  = '0;
    end
  end

  // ===================================================================
  // State register with clock enable and synchronous reset.
  // A low clock enable holds every field, the pin filter count included,
  // so a frozen core does not age a reset pulse on the pin.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      s_reg         <= '0;
      s_reg.state   <= smcg_pkg::SMCG_RESET;
      s_reg.mode    <= `SMCG_MODE_IDLE;
    end else if (i_clk_en) begin
      s_reg <= s_next;
    end
  end

  // ===================================================================
  // Port pins: one copy of the pad logic per bit.
  // The pads are plain gates on the reset sources, so they float with no
  // clock edge, but leave a filtered reset only at an enabled edge. The cost is that a short glitch on the
  // reset pin also releases the pins for as long as it lasts.
  for (genvar b = 0; b < NPORTS*PORT_W; b++) begin : g_pin
    // Output enable and pull-up both drop during reset.
    assign o_pin_oe[b]     = i_port_dir[b] & ~rst_any;
    assign o_pin_out[b]    = i_port_out[b] & ~rst_any;
    assign o_pin_pullup[b] = i_port_pullup[b] & ~i_port_dir[b] & ~rst_any;
    assign o_port_in[b]    = i_pin_in[b];
  end

  // ===================================================================
  // Status outputs.
  // All of these but the reset flag decode registered state, so they
  // move only at clock edges that are enabled or carry i_rst.
  assign o_gate         = s_reg.gate;
  assign o_sleeping     = (s_reg.state == smcg_pkg::SMCG_SLEEP);
  assign o_cpu_run      = s_reg.gate.cpu;
  assign o_reset_active = rst_any;

endmodule : smcg_ctrl

// >>> smcg_defines.svh
// Constants for the sleep mode and clock gating controller.
`ifndef SMCG_DEFINES_SVH
`define SMCG_DEFINES_SVH
// =====================================================================
// Sleep mode field encoding.
`define SMCG_MODE_W        3
`define SMCG_MODE_IDLE     3'h0
`define SMCG_MODE_ADCNR    3'h1
`define SMCG_MODE_PDOWN    3'h2
`define SMCG_MODE_PSAVE    3'h3
`define SMCG_MODE_STBY     3'h6
`define SMCG_MODE_XSTBY    3'h7
// =====================================================================
// Port geometry.
`define SMCG_PORT_W        8
`define SMCG_NUM_PORTS     4
// =====================================================================
// Timing: oscillator start-up after a stopped oscillator, and the
// shorter resync time when the oscillator kept running.
`define SMCG_CLK_MHZ       40
`define SMCG_OSC_START_NS  1000
`define SMCG_OSC_START_CYC ((`SMCG_OSC_START_NS * `SMCG_CLK_MHZ + 999) / 1000)
`define SMCG_FAST_WAKE_CYC 6
`define SMCG_CNT_W         16
// Reset pin minimum low pulse length.
`define SMCG_RST_MIN_NS    2500
`define SMCG_RST_MIN_CYC   ((`SMCG_RST_MIN_NS * `SMCG_CLK_MHZ + 999) / 1000)
`endif

// >>> smcg_pkg.sv
// Types shared by the sleep mode and clock gating controller.
package smcg_pkg;
  // ===================================================================
  // Controller states, one-hot.
  typedef enum logic [3:0] {
    SMCG_ACTIVE = 4'h1,  // CPU running.
    SMCG_SLEEP  = 4'h2,  // Sleeping in the selected mode.
    SMCG_WAKE   = 4'h4,  // Waiting for oscillator stability.
    SMCG_RESET  = 4'h8   // Reset held.
  } smcg_state_e;

  // Clock and function enables handed to the rest of the chip.
  typedef struct packed {
    logic cpu;     // CPU clock.
    logic sram;    // SRAM clock.
    logic timer;   // Synchronous timer/counters.
    logic spi;     // SPI port.
    logic irq;     // Interrupt logic.
    logic adc;     // Analog-to-digital converter.
    logic async;   // Asynchronous timer.
    logic osc;     // Main oscillator.
  } smcg_gate_s;

  // Whole state of the controller.
  typedef struct packed {
    smcg_state_e state;
    logic [2:0]  mode;
    logic [15:0] cnt;
    logic [15:0] rst_cnt;
    logic        int_rst;
    smcg_gate_s  gate;
  } smcg_all_s;
endpackage : smcg_pkg

// >>> smcg_ctrl_sva.sv
// Port-level assertions for the sleep mode and clock gating controller.
`timescale 1ns/1ps
module smcg_ctrl_sva #(
  parameter int unsigned PORT_W   = 8,
  parameter int unsigned NPORTS   = 4,
  parameter int unsigned OSC_CYC  = 40,
  parameter int unsigned FAST_CYC = 6
) (
  input wire logic                     i_core_clk,
  input wire logic                     i_rst,
  input wire logic                     i_clk_en,
  input wire logic                     i_sleep_req,
  input wire logic [2:0]               i_sleep_mode,
  input wire logic                     i_wake_irq,
  input wire logic [NPORTS*PORT_W-1:0] i_port_dir,
  input wire logic [NPORTS*PORT_W-1:0] o_pin_oe,
  input wire logic [NPORTS*PORT_W-1:0] o_pin_pullup,
  input wire smcg_pkg::smcg_gate_s     o_gate,
  input wire logic                     o_sleeping,
  input wire logic                     o_cpu_run,
  input wire logic                     o_reset_active
);
  // Expected gate pattern per mode code, code 7 in the top byte.
  localparam logic [63:0] GTAB = {8'h03, 8'h01, 8'h00, 8'h00, 8'h02, 8'h00, 8'h07, 8'h7b};
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  logic        take;    // A sleep request that the controller must act on.
  logic [15:0] wait_q;  // Enabled cycles spent waking so far.
  logic        fast_q;  // The oscillator stayed on during the last sleep.
  logic        woke_q;  // A wake from sleep is being timed.
  assign take = i_clk_en && o_cpu_run && !o_sleeping && !o_reset_active && i_sleep_req;
  // =====================================================================
  // Wake timer: a wake after reset is not timed, so its longer path is excluded.
  always_ff @(posedge i_core_clk) begin
    if (i_rst || o_reset_active) begin
      wait_q <= '0;
      woke_q <= 1'b0;
      fast_q <= 1'b0;
    end else if (o_sleeping) begin
      wait_q <= '0;
      woke_q <= 1'b1;
      fast_q <= o_gate.osc;
    end else if (i_clk_en && !o_cpu_run) begin
      wait_q <= wait_q + 16'h1;
    end
  end
  // =====================================================================
  // Assertions.
  pins_tristate_a: assert property (o_reset_active |-> o_pin_oe == '0 && o_pin_pullup == '0)
    else $error("pins not released in reset");
  pin_dir_a: assert property (!o_reset_active |-> o_pin_oe == i_port_dir && (o_pin_pullup & i_port_dir) == '0)
    else $error("pin drive or pull-up wrong");
  mode_gate_a: assert property (take && i_sleep_mode[2:1] != 2'b10 |=> o_sleeping && o_gate == GTAB[8*$past(i_sleep_mode) +: 8])
    else $error("sleep gates wrong for mode");
  reserved_code_a: assert property (take && i_sleep_mode[2:1] == 2'b10 |=> !o_sleeping && o_cpu_run)
    else $error("reserved mode entered sleep");
  sleep_hold_a: assert property (o_sleeping && !i_wake_irq && i_clk_en && !o_reset_active |=> o_sleeping && $stable(o_gate))
    else $error("sleep left without wake");
  cpu_stopped_a: assert property (o_sleeping |-> !o_cpu_run && !o_gate.cpu)
    else $error("cpu clock on in sleep");
  wake_gate_a: assert property (o_sleeping && i_wake_irq && i_clk_en && !o_reset_active |=> !o_sleeping && o_gate == 8'h7f)
    else $error("wake gates wrong");
  wake_time_a: assert property ($rose(o_cpu_run) && woke_q |-> wait_q == (fast_q ? FAST_CYC : OSC_CYC))
    else $error("wake latency wrong");
endmodule : smcg_ctrl_sva

bind smcg_ctrl smcg_ctrl_sva #(.PORT_W(PORT_W), .NPORTS(NPORTS), .OSC_CYC(OSC_CYC), .FAST_CYC(FAST_CYC)) u_sva (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_clk_en(i_clk_en), .i_sleep_req(i_sleep_req),
  .i_sleep_mode(i_sleep_mode), .i_wake_irq(i_wake_irq), .i_port_dir(i_port_dir),
  .o_pin_oe(o_pin_oe), .o_pin_pullup(o_pin_pullup), .o_gate(o_gate), .o_sleeping(o_sleeping),
  .o_cpu_run(o_cpu_run), .o_reset_active(o_reset_active));

// >>> smcg_tb.sv
// Self-checking bench for the sleep mode and clock gating controller.
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module testbench;
  // Expected gate pattern per mode code, code 7 in the top byte.
  localparam logic [63:0] GTAB = {8'h03, 8'h01, 8'h00, 8'h00, 8'h02, 8'h00, 8'h07, 8'h7b};
  logic        clk = 1'b0, rst = 1'b1, en = 1'b1, rn = 1'b1, req = 1'b0, irq = 1'b0;
  logic [2:0]  mode = 3'h0;
  logic [31:0] pout = 32'ha5a5_5a5a, pdir = 32'h0000_ffff, pup = 32'hff00_ff00;
  logic [31:0] pin = 32'h1234_5678, pin_out, oe, pu, pin_rd;
  logic [7:0]  gate;  // Gate enables seen as a plain vector.
  logic        slp, cpu, ra;
  int          fails = 0, comparisons = 0;
  always #12.5 clk = ~clk;
  smcg_ctrl DUT (.i_core_clk(clk), .i_rst(rst), .i_clk_en(en), .i_reset_n(rn), .i_sleep_req(req),
    .i_sleep_mode(mode), .i_wake_irq(irq), .i_port_out(pout), .i_port_dir(pdir),
    .i_port_pullup(pup), .i_pin_in(pin), .o_pin_out(pin_out), .o_pin_oe(oe), .o_pin_pullup(pu),
    .o_port_in(pin_rd), .o_gate(gate), .o_sleeping(slp), .o_cpu_run(cpu), .o_reset_active(ra));
  // =====================================================================
  // Shared tasks.
  task automatic end_of_test();
    if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // Counts cycles until the CPU clock returns; a stuck wake ends the run.
  task automatic wait_cpu(output int n);
    n = 0;
    while (cpu !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 300) begin
        fails++;
        end_of_test();
      end
    end
  endtask : wait_cpu
  // =====================================================================
  // Scenarios.
  task automatic do_reset();
    int n;
    rst = 1'b1;
    repeat (20) @(negedge clk);
    `CHK("gate in reset", 8'h00, gate)
    `CHK("oe in reset", 32'h0, oe)
    rst = 1'b0;
    wait_cpu(n);
    `CHK("reset wake time", 41, n)
  endtask : do_reset
  // Sleeps in one mode, repeats the request while asleep, then wakes.
  task automatic sleep_wake(input logic [2:0] m, input int w);
    int n;
    mode = m;
    req = 1'b1;
    @(negedge clk);
    `CHK("sleeping", 1'b1, slp)
    `CHK("sleep gate", GTAB[8*m +: 8], gate)
    repeat (5) @(negedge clk);
    req = 1'b0;
    `CHK("held gate", GTAB[8*m +: 8], gate)
    irq = 1'b1;
    @(negedge clk);
    irq = 1'b0;
    `CHK("wake gate", 8'h7f, gate)
    wait_cpu(n);
    `CHK("wake time", w, n)
  endtask : sleep_wake
  // Pins, reserved codes, a frozen clock enable and reset pin pulses.
  task automatic misc();
    int n;
    @(negedge clk);
    `CHK("oe", pdir, oe)
    `CHK("pullup", pup & ~pdir, pu)
    `CHK("out", pout & pdir, pin_out & pdir)
    `CHK("in", pin, pin_rd)
    // The request stays high across both codes, never set twice in one step.
    req = 1'b1;
    for (int m = 4; m < 6; m++) begin
      mode = m[2:0];
      @(negedge clk);
      `CHK("reserved", 1'b0, slp)
    end
    en = 1'b0;
    mode = 3'h2;
    @(negedge clk);
    req = 1'b0;
    en = 1'b1;
    `CHK("frozen", 1'b0, slp)
    rn = 1'b0;
    repeat (20) @(negedge clk);
    `CHK("oe pin reset", 32'h0, oe)
    `CHK("out pin reset", 32'h0, pin_out)
    `CHK("reset flag", 1'b1, ra)
    rn = 1'b1;
    @(negedge clk);
    `CHK("short pulse", 1'b1, cpu)
    rn = 1'b0;
    repeat (110) @(negedge clk);
    `CHK("long pulse", 1'b0, cpu)
    rn = 1'b1;
    wait_cpu(n);
  endtask : misc
  initial begin
    do_reset();
    misc();
    sleep_wake(3'h0, 6);
    sleep_wake(3'h1, 6);
    sleep_wake(3'h2, 40);
    sleep_wake(3'h3, 40);
    sleep_wake(3'h6, 6);
    sleep_wake(3'h7, 6);
    do_reset();
    end_of_test();
  end
endmodule : testbench
